// File: verilog/apk_consts.vh
/*
 Constants of the audio packetizer: buffer geometry, status codes,
 source sizes and serial receiver counts.
 Assumes inclusion by bare name from the packetizer design files.
*/
`ifndef APK_CONSTS_VH
`define APK_CONSTS_VH

// Buffer geometry
`define APK_ENTRY_W 36
`define APK_DATA_W 32
`define APK_CODE_W 4
`define APK_DEPTH 35
`define APK_FULL_LVL 6'h22
`define APK_AFULL_LVL 6'h20
`define APK_CNT_W 6
`define APK_PTR_W 6

// Status codes carried in the upper nibble
`define APK_CODE_FIELD_START 4'h6
`define APK_CODE_LINE_START 4'h2
`define APK_CODE_VALID 4'h1
`define APK_CODE_LINE_END1 4'hD
`define APK_CODE_LINE_END2 4'hE
`define APK_CODE_LINE_END3 4'hF
`define APK_CODE_LINE_END4 4'hA
`define APK_CODE_FIELD_END 4'hC

// Byte counts of one input unit
`define APK_NB_BYTE 3'h1
`define APK_NB_HALF 3'h2
`define APK_NB_WORD 3'h4

// Serial receiver counts
`define APK_SAMPLE_LAST 5'h0F
`define APK_BYTE_LAST 5'h07
`define APK_EDGE_CNT_MAX 6'h3F

// Capture states
`define APK_ST_IDLE 2'h0
`define APK_ST_FSTART 2'h1
`define APK_ST_RUN 2'h2
`define APK_ST_FEND 2'h3

`endif

// File: verilog/apk_fifo_mem.v
/*
 Storage of the audio buffer: a circular word memory with registered
 read data. Assumes the caller never writes when full nor reads when empty.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apk_consts.vh"

module apk_fifo_mem #(
    parameter WIDTH = `APK_ENTRY_W,
    parameter DEPTH = `APK_DEPTH,
    parameter AW = `APK_PTR_W
) (
    // Clock and reset
    input wire clock,
    input wire resetn,
    input wire clear,
    // Write side
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    // Read side
    input wire rd_en,
    output reg [WIDTH-1:0] rd_data_q
);
    localparam [AW-1:0] LAST = DEPTH - 1;
    localparam [AW-1:0] ONE = 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;

    // Pointers wrap at the last entry, cleared with the buffer
    always @(posedge clock) begin
        if (!resetn || clear) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            rd_data_q <= {WIDTH{1'b0}};
        end else begin
            if (wr_en) begin
                wr_ptr_q <= (wr_ptr_q == LAST) ? {AW{1'b0}} : wr_ptr_q + ONE;
            end
            if (rd_en) begin
                rd_data_q <= mem[rd_ptr_q];
                rd_ptr_q <= (rd_ptr_q == LAST) ? {AW{1'b0}} : rd_ptr_q + ONE;
            end
        end
    end

    // Array itself holds no reset
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_ptr_q] <= wr_data;
        end
    end
endmodule // apk_fifo_mem

`default_nettype wire

// File: verilog/apk_packetizer.v
/*
 Audio packetizer: serial audio receiver, digitizer input, word packer,
 line and field framing, and the audio buffer with its occupancy count.
 Assumes all control ports and the digitizer strobe are on clock; the
 three serial pins are asynchronous and are resampled here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apk_consts.vh"

// How it works
// - Buffer entries are 36 bits: 32 data bits under a 4-bit status nibble.
// - Buffer holds 35 entries; full flag at 34, almost-full flag at 32.
// - A push is always followed by at least one cycle without push.
// - Six-bit occupancy clears while buffer disabled, else counts pushes below 35 entries up, pops down.
// - Capture enable high makes the first word a field-start word, data unused.
// - A line over four bytes is a start word, middle valid words, then one end word; a shorter line is one end word.
// - Lines start word aligned; last word holds 1-4 right-justified bytes, code says count.
// - Line length governs end codes; bytes past the line end are dropped.
// - Sample width select picks 16-bit or byte digitizer units; halves pack little-endian.
// - In two-channel mode each sample pair forms one word.
// - After field_line_count lines a field-end word is written, then a new field.
// - Clearing capture enable stops only after the field-end word.
// - Buffer disable stops writes at once and restarts capture at field start.
// - Bit clock resampled by system clock; data and sync sampled on its edges.
// - Serial mode select: zero two-channel audio, one framed packet bytes.
// - Sampling edge select: zero rising, one falling bit-clock edge.
// - Channel order sets which sync edge leads; leading sample goes in low half.
// - First bit appears first_bit_delay bit clocks after each sync edge.
// - Bit order select: zero most significant first, one least significant first.
// - Surplus bit clocks between sync edges are ignored; gaps are tolerated.
// - Packet bytes every 8 bit clocks, only line length bytes per frame.
// - In packet mode channel order picks the frame sync edge.
module apk_packetizer #(
    parameter LEN_W = 12,
    parameter LINES_W = 10
) (
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Serial pins
    input wire serial_bit_clock,
    input wire word_select_sync,
    input wire serial_audio_input,
    // Control
    input wire buffer_enable,
    input wire capture_enable_bit,
    input wire source_serial,
    input wire serial_mode_select,
    input wire sampling_edge_select,
    input wire channel_order_bit,
    input wire [4:0] first_bit_delay,
    input wire bit_order_select,
    input wire sample_width_select,
    input wire [LEN_W-1:0] line_byte_length,
    input wire [LINES_W-1:0] field_line_count,
    // Digitizer samples
    input wire digitizer_valid,
    input wire [15:0] digitizer_data,
    // Buffer drain
    input wire buffer_pop,
    output wire [`APK_ENTRY_W-1:0] buffer_data_q,
    output reg [`APK_CNT_W-1:0] buffer_count_q,
    output reg buffer_full_q,
    output reg buffer_almost_full_q,
    output reg buffer_push_q,
    output reg capture_active_q
);
    reg [2:0] sclk_s_q;
    reg [2:0] ws_s_q;
    reg [2:0] sd_s_q;
    reg sclk_f_q, ws_f_q, sd_f_q, sclk_p_q, ws_prev_q;
    reg [5:0] edge_cnt_q;
    reg [4:0] nbits_q;
    reg [15:0] shift_q;
    reg [15:0] lead_hold_q;
    reg lead_q, have_lead_q, frame_q;
    reg [LEN_W-1:0] frame_bytes_q;
    reg ser_v_q;
    reg [31:0] ser_d_q;
    reg [2:0] ser_nb_q;
    reg [1:0] state_q;
    reg [31:0] acc_q;
    reg [1:0] acc_n_q;
    reg [LEN_W-1:0] left_q;
    reg first_q;
    reg [LINES_W-1:0] lines_q;
    reg [`APK_ENTRY_W-1:0] pend_q;
    reg pend_v_q;
    wire sclk_rise, sclk_fall, samp, ws_edge, lead_edge, bit_ok;
    wire [5:0] cur_cnt;
    wire [15:0] shift_d;
    wire [7:0] byte_d;
    wire [15:0] sample_d;
    reg in_v;
    reg [31:0] in_d;
    reg [2:0] in_nb, eff, tot;
    reg [31:0] mask, merged;
    reg [`APK_CODE_W-1:0] end_code;
    wire last_of_line, push_d, wr_en, rd_en;
    reg [`APK_CNT_W-1:0] cnt_d;

    // Three-stage resampling; a level counts once stages two and three agree
    always @(posedge clock) begin
        if (!resetn) begin
            sclk_s_q <= 3'h0;
            ws_s_q <= 3'h0;
            sd_s_q <= 3'h0;
            sclk_f_q <= 1'b0;
            ws_f_q <= 1'b0;
            sd_f_q <= 1'b0;
            sclk_p_q <= 1'b0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], serial_bit_clock};
            ws_s_q <= {ws_s_q[1:0], word_select_sync};
            sd_s_q <= {sd_s_q[1:0], serial_audio_input};
            if (sclk_s_q[1] == sclk_s_q[2]) sclk_f_q <= sclk_s_q[2];
            if (ws_s_q[1] == ws_s_q[2]) ws_f_q <= ws_s_q[2];
            if (sd_s_q[1] == sd_s_q[2]) sd_f_q <= sd_s_q[2];
            sclk_p_q <= sclk_f_q;
        end
    end

    // Edge finding on the resampled bit clock
    assign sclk_rise = sclk_f_q & ~sclk_p_q;
    assign sclk_fall = ~sclk_f_q & sclk_p_q;
    assign samp = sampling_edge_select ? sclk_fall : sclk_rise;
    // Leading or frame edge: rising when channel order is zero
    assign lead_edge = ws_f_q ^ channel_order_bit;
    assign ws_edge = (ws_f_q != ws_prev_q) & (~serial_mode_select | lead_edge);
    assign cur_cnt = ws_edge ? 6'h00 : ((edge_cnt_q == `APK_EDGE_CNT_MAX) ? edge_cnt_q : edge_cnt_q + 6'h01);
    assign bit_ok = (cur_cnt >= {1'b0, first_bit_delay});
    assign shift_d = bit_order_select ? {sd_f_q, shift_q[15:1]} : {shift_q[14:0], sd_f_q};
    assign byte_d = bit_order_select ? {sd_f_q, shift_q[7:1]} : {shift_q[6:0], sd_f_q};
    assign sample_d = shift_d;

    // Serial receiver: two-channel samples or framed packet bytes
    always @(posedge clock) begin
        if (!resetn || !buffer_enable) begin
            ws_prev_q <= 1'b0;
            edge_cnt_q <= `APK_EDGE_CNT_MAX;
            nbits_q <= 5'h00;
            shift_q <= 16'h0000;
            lead_hold_q <= 16'h0000;
            lead_q <= 1'b0;
            have_lead_q <= 1'b0;
            frame_q <= 1'b0;
            frame_bytes_q <= {LEN_W{1'b0}};
            ser_v_q <= 1'b0;
            ser_d_q <= 32'h00000000;
            ser_nb_q <= `APK_NB_WORD;
        end else begin
            ser_v_q <= 1'b0;
            if (samp) begin
                ws_prev_q <= ws_f_q;
                edge_cnt_q <= cur_cnt;
                if (ws_edge) begin
                    nbits_q <= 5'h00;
                    lead_q <= lead_edge;
                    frame_q <= (state_q == `APK_ST_RUN);
                    frame_bytes_q <= {LEN_W{1'b0}};
                end
                if (!serial_mode_select) begin
                    // Collect 16 bits then ignore surplus clocks
                    if (bit_ok && (ws_edge || nbits_q <= `APK_SAMPLE_LAST)) begin
                        shift_q <= shift_d;
                        nbits_q <= (ws_edge ? 5'h00 : nbits_q) + 5'h01;
                        if (!ws_edge && nbits_q == `APK_SAMPLE_LAST) begin
                            if (lead_q) begin
                                lead_hold_q <= sample_d;
                                have_lead_q <= 1'b1;
                            end else if (have_lead_q) begin
                                ser_v_q <= 1'b1;
                                ser_d_q <= {sample_d, lead_hold_q};
                                ser_nb_q <= `APK_NB_WORD;
                                have_lead_q <= 1'b0;
                            end
                        end
                    end
                end else if ((ws_edge ? (state_q == `APK_ST_RUN) : (frame_q && frame_bytes_q != line_byte_length)) &&
                             bit_ok) begin
                    // Byte every eight bit clocks inside the frame; a bit on the sync edge counts as the first
                    shift_q <= {8'h00, byte_d};
                    nbits_q <= ws_edge ? 5'h01 : ((nbits_q == `APK_BYTE_LAST) ? 5'h00 : nbits_q + 5'h01);
                    if (!ws_edge && nbits_q == `APK_BYTE_LAST) begin
                        ser_v_q <= 1'b1;
                        ser_d_q <= {24'h000000, byte_d};
                        ser_nb_q <= `APK_NB_BYTE;
                        frame_bytes_q <= frame_bytes_q + {{(LEN_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end

    // Source choice and unit size
    always @* begin
        if (source_serial) begin
            in_v = ser_v_q;
            in_d = ser_d_q;
            in_nb = ser_nb_q;
        end else begin
            in_v = digitizer_valid;
            in_d = sample_width_select ? {24'h000000, digitizer_data[7:0]} : {16'h0000, digitizer_data};
            in_nb = sample_width_select ? `APK_NB_BYTE : `APK_NB_HALF;
        end
    end

    // Packing arithmetic: bytes past the line end are cut off
    always @* begin
        eff = ({{(LEN_W-3){1'b0}}, in_nb} > left_q) ? left_q[2:0] : in_nb;
        tot = {1'b0, acc_n_q} + eff;
        case (eff)
            3'h1: mask = 32'h000000FF;
            3'h2: mask = 32'h0000FFFF;
            3'h3: mask = 32'h00FFFFFF;
            default: mask = 32'hFFFFFFFF;
        endcase
        merged = acc_q | ((in_d & mask) << {acc_n_q, 3'h0});
        case (tot)
            3'h1: end_code = `APK_CODE_LINE_END1;
            3'h2: end_code = `APK_CODE_LINE_END2;
            3'h3: end_code = `APK_CODE_LINE_END3;
            default: end_code = `APK_CODE_LINE_END4;
        endcase
    end
    assign last_of_line = ({{(LEN_W-3){1'b0}}, eff} == left_q);

    // Capture sequence: field start, lines, field end
    always @(posedge clock) begin
        if (!resetn || !buffer_enable) begin
            state_q <= `APK_ST_IDLE;
            acc_q <= 32'h00000000;
            acc_n_q <= 2'h0;
            left_q <= {LEN_W{1'b0}};
            first_q <= 1'b1;
            lines_q <= {LINES_W{1'b0}};
            pend_q <= {`APK_ENTRY_W{1'b0}};
            pend_v_q <= 1'b0;
            capture_active_q <= 1'b0;
        end else begin
            if (push_d) pend_v_q <= 1'b0;
            capture_active_q <= (state_q != `APK_ST_IDLE);
            case (state_q)
                `APK_ST_IDLE: begin
                    if (capture_enable_bit) state_q <= `APK_ST_FSTART;
                end
                `APK_ST_FSTART: begin
                    if (!pend_v_q) begin
                        pend_q <= {`APK_CODE_FIELD_START, 32'h00000000};
                        pend_v_q <= 1'b1;
                        acc_q <= 32'h00000000;
                        acc_n_q <= 2'h0;
                        left_q <= line_byte_length;
                        first_q <= 1'b1;
                        lines_q <= {LINES_W{1'b0}};
                        state_q <= `APK_ST_RUN;
                    end
                end
                `APK_ST_RUN: begin
                    if (in_v && !pend_v_q && left_q != {LEN_W{1'b0}}) begin
                        left_q <= left_q - {{(LEN_W-3){1'b0}}, eff};
                        if (last_of_line || tot[2]) begin
                            pend_v_q <= 1'b1;
                            acc_q <= 32'h00000000;
                            acc_n_q <= 2'h0;
                            first_q <= 1'b0;
                            if (last_of_line) begin
                                pend_q <= {end_code, merged};
                                left_q <= line_byte_length;
                                first_q <= 1'b1;
                                lines_q <= lines_q + {{(LINES_W-1){1'b0}}, 1'b1};
                                if (lines_q + {{(LINES_W-1){1'b0}}, 1'b1} == field_line_count) begin
                                    state_q <= `APK_ST_FEND;
                                end
                            end else begin
                                pend_q <= {first_q ? `APK_CODE_LINE_START : `APK_CODE_VALID, merged};
                            end
                        end else begin
                            acc_q <= merged;
                            acc_n_q <= tot[1:0];
                        end
                    end
                end
                `APK_ST_FEND: begin
                    if (!pend_v_q) begin
                        pend_q <= {`APK_CODE_FIELD_END, 32'h00000000};
                        pend_v_q <= 1'b1;
                        state_q <= capture_enable_bit ? `APK_ST_FSTART : `APK_ST_IDLE;
                    end
                end
                default: state_q <= `APK_ST_IDLE;
            endcase
        end
    end

    // Push spacing: never two pushes on adjacent cycles
    assign push_d = pend_v_q & ~buffer_push_q;
    assign wr_en = push_d & buffer_enable & (buffer_count_q < `APK_DEPTH);
    assign rd_en = buffer_pop & (buffer_count_q != {`APK_CNT_W{1'b0}});

    // Occupancy count and threshold flags
    always @* begin
        cnt_d = buffer_count_q;
        if (wr_en && !rd_en) cnt_d = buffer_count_q + 6'h01;
        if (rd_en && !wr_en) cnt_d = buffer_count_q - 6'h01;
    end
    always @(posedge clock) begin
        if (!resetn || !buffer_enable) begin
            buffer_count_q <= {`APK_CNT_W{1'b0}};
            buffer_full_q <= 1'b0;
            buffer_almost_full_q <= 1'b0;
            buffer_push_q <= 1'b0;
        end else begin
            buffer_count_q <= cnt_d;
            buffer_full_q <= (cnt_d >= `APK_FULL_LVL);
            buffer_almost_full_q <= (cnt_d >= `APK_AFULL_LVL);
            buffer_push_q <= push_d;
        end
    end

    // Buffer storage, 36 by 35
    apk_fifo_mem #(
        .WIDTH(`APK_ENTRY_W),
        .DEPTH(`APK_DEPTH),
        .AW(`APK_PTR_W)
    ) u_mem (
        .clock(clock),
        .resetn(resetn),
        .clear(~buffer_enable),
        .wr_en(wr_en),
        .wr_data(pend_q),
        .rd_en(rd_en),
        .rd_data_q(buffer_data_q)
    );
endmodule // apk_packetizer

`default_nettype wire

// File: verification/apk_packetizer_chk.sv
/*
 Checker of the audio packetizer: buffer count, push spacing, disable
 and capture start relations seen at the top module's ports.
 Assumes binding into apk_packetizer and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apk_consts.vh"

module apk_packetizer_chk #(
    parameter LEN_W = 12,
    parameter LINES_W = 10
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic buffer_enable,
    input wire logic capture_enable_bit,
    input wire logic buffer_pop,
    // Buffer status
    input wire logic [`APK_CNT_W-1:0] buffer_count_q,
    input wire logic buffer_full_q,
    input wire logic buffer_almost_full_q,
    input wire logic buffer_push_q,
    input wire logic capture_active_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // Buffer writes and count bounds
    AST_PUSH_GAP: assert property (buffer_push_q |=> !buffer_push_q)
        else $error("push strobe on two adjacent cycles");
    AST_DEPTH: assert property (buffer_count_q <= 6'h23)
        else $error("occupancy above buffer depth");
    AST_FLAGS: assert property ($stable(buffer_count_q) |->
        (buffer_full_q == (buffer_count_q >= `APK_FULL_LVL)) && (buffer_almost_full_q == (buffer_count_q >= `APK_AFULL_LVL)))
        else $error("full flags disagree with occupancy");
    AST_CNT_STEP: assert property ((buffer_enable && $past(buffer_enable)) |->
        ((buffer_count_q - $past(buffer_count_q) + 6'h01) <= 6'h02))
        else $error("occupancy moved by more than one");
    AST_POP_DOWN: assert property ((buffer_enable && buffer_pop && buffer_count_q != 6'h00) |=>
        buffer_count_q <= $past(buffer_count_q))
        else $error("occupancy rose across a pop");
    AST_CNT_CLEAR: assert property (!buffer_enable |=> buffer_count_q == 6'h00)
        else $error("occupancy not cleared while disabled");
    // Disable halts writes and returns capture to idle
    AST_HALT: assert property (!buffer_enable [*2] |=> !buffer_push_q)
        else $error("push while buffer disabled");
    AST_RESTART: assert property (!buffer_enable [*3] |=> !capture_active_q)
        else $error("capture still active while disabled");
    AST_START_CAUSE: assert property ($rose(capture_active_q) |->
        ($past(capture_enable_bit) || $past(capture_enable_bit, 2) || $past(capture_enable_bit, 3)))
        else $error("capture started without enable");

    // Main scenarios reached
    cover property (buffer_full_q);
    cover property ($rose(capture_active_q));
    cover property ($fell(capture_active_q));
endmodule // apk_packetizer_chk

bind apk_packetizer apk_packetizer_chk #(.LEN_W(LEN_W), .LINES_W(LINES_W)) i_apk_packetizer_chk (
    .clock(clock), .resetn(resetn), .buffer_enable(buffer_enable), .capture_enable_bit(capture_enable_bit),
    .buffer_pop(buffer_pop), .buffer_count_q(buffer_count_q), .buffer_full_q(buffer_full_q),
    .buffer_almost_full_q(buffer_almost_full_q), .buffer_push_q(buffer_push_q), .capture_active_q(capture_active_q));
`default_nettype wire

// File: verification/apk_serial_src.sv
/*
 Model of the external serial audio source on the three serial pins.
 Assumes the bench calls send_pair or send_frame; the bit clock stands still between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module apk_serial_src (
    // Serial pins toward the packetizer
    output logic sclk,
    output logic ws,
    output logic sdat
);
    // Idle pins before the first frame
    initial begin
        sclk = 1'h0;
        ws = 1'h0;
        sdat = 1'h0;
    end

    // One left and right pair, 20 bit clocks per half, data moves on the non-sampling edge
    task automatic send_pair(input logic [15:0] l, input logic [15:0] r, input logic sce, input logic lsb,
                             input int dly);
        logic [15:0] w;
        for (int h = 0; h < 2; h++) begin
            w = h ? r : l;
            for (int i = 0; i < 20; i++) begin
                sclk = sce;
                ws = (h == 0);
                sdat = (i >= dly && i < dly + 16) ? w[lsb ? i - dly : 15 - i + dly] : ~sdat;
                #62.5;
                sclk = ~sce;
                #62.5;
            end
        end
        sclk = sce;
        sdat = ~sdat; // Released line shows no stale value
    endtask

    // One packet frame: sync rises with the first bit, bytes of the bench pattern back to back
    task automatic send_frame(input int n, input int base, input logic sce, input logic lsb);
        logic [7:0] b;
        for (int i = 0; i < n * 8; i++) begin
            b = 8'((base + i / 8) * 'h25 + 'h0B);
            sclk = sce;
            ws = (i < 8);
            sdat = b[lsb ? i % 8 : 7 - i % 8];
            #62.5;
            sclk = ~sce;
            #62.5;
        end
        sclk = sce;
        sdat = ~sdat;
    endtask
endmodule // apk_serial_src
`default_nettype wire

// File: verification/tb_top.sv
/*
 Testbench of the audio packetizer: digitizer and serial capture runs and
 overflow, each checked word by word after draining, and buffer disable.
 Assumes apk_serial_src as the serial source and a 4 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apk_consts.vh"

module tb_top;
    // Stimulus and observation
    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic buf_en = 1'h0, cap_en = 1'h0, src_ser = 1'h0, wsel = 1'h0, sce = 1'h0, lsb = 1'h0;
    logic dig_v = 1'h0, pop = 1'h0, pkt = 1'h0;
    logic [4:0] dly = 5'h00;
    logic [15:0] dig_d = 16'h0000;
    logic [11:0] len = 12'h004;
    logic [9:0] lines = 10'h001;
    wire sclk, ws, sdat, full, afull, push, active;
    wire [35:0] q;
    wire [5:0] cnt;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    logic [35:0] exp_q[$], msk_q[$];

    apk_serial_src i_apk_serial_src (.sclk(sclk), .ws(ws), .sdat(sdat));

    apk_packetizer i_apk_packetizer (
        .clock(clock), .resetn(resetn), .serial_bit_clock(sclk), .word_select_sync(ws),
        .serial_audio_input(sdat), .buffer_enable(buf_en), .capture_enable_bit(cap_en),
        .source_serial(src_ser), .serial_mode_select(pkt), .sampling_edge_select(sce),
        .channel_order_bit(1'h0), .first_bit_delay(dly), .bit_order_select(lsb),
        .sample_width_select(wsel), .line_byte_length(len), .field_line_count(lines),
        .digitizer_valid(dig_v), .digitizer_data(dig_d), .buffer_pop(pop), .buffer_data_q(q),
        .buffer_count_q(cnt), .buffer_full_q(full), .buffer_almost_full_q(afull),
        .buffer_push_q(push), .capture_active_q(active));

    // Clock and hang guard
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [35:0] got, input logic [35:0] exp, input logic [35:0] m, input string what);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Byte pattern of the source stream
    function automatic logic [7:0] bval(input int i);
        return 8'(i * 'h25 + 'h0B);
    endfunction

    // Expected words of one field
    task automatic build_exp(input int ln, input int nl);
        int rem;
        logic [3:0] c;
        logic [31:0] d, m;
        exp_q.push_back({`APK_CODE_FIELD_START, 32'h0});
        msk_q.push_back(36'hF00000000);
        for (int l = 0; l < nl; l++) begin
            for (int w = 0; w * 4 < ln; w++) begin
                rem = ln - w * 4;
                for (int b = 0; b < 4; b++) d[b*8 +: 8] = bval(l * ln + w * 4 + b);
                m = (rem >= 4) ? 32'hFFFFFFFF : ((32'h1 << (rem * 8)) - 32'h1);
                case (rem)
                    1: c = `APK_CODE_LINE_END1;
                    2: c = `APK_CODE_LINE_END2;
                    3: c = `APK_CODE_LINE_END3;
                    4: c = `APK_CODE_LINE_END4;
                    default: c = (w == 0) ? `APK_CODE_LINE_START : `APK_CODE_VALID;
                endcase
                exp_q.push_back({c, d});
                msk_q.push_back({4'hF, m});
            end
        end
        exp_q.push_back({`APK_CODE_FIELD_END, 32'h0});
        msk_q.push_back(36'hF00000000);
    endtask

    task automatic wait_active(input logic v);
        for (int i = 0; i < 4000 && active !== v; i++) @(posedge clock);
        check({35'h0, active}, {35'h0, v}, 36'h1, "capture state");
    endtask

    // One field from digitizer or serial pins, then drain and compare
    task automatic run(input logic ser, input logic ws8, input int ln, input int nl);
        int n;
        src_ser <= ser;
        wsel <= ws8;
        len <= ln[11:0];
        lines <= nl[9:0];
        cap_en <= 1'h1;
        wait_active(1'h1);
        cap_en <= 1'h0;
        repeat (8) @(posedge clock);
        build_exp(ln, nl);
        for (int l = 0; l < nl && !ser; l++)
            for (int j = 0; j < ln; j += (ws8 ? 1 : 2)) begin
                dig_d <= {bval(l * ln + j + 1), bval(l * ln + j)};
                dig_v <= 1'h1;
                @(posedge clock);
                dig_v <= 1'h0;
                repeat (3) @(posedge clock);
            end
        for (int k = 0; k < ln / 4 && ser && !pkt; k++)
            i_apk_serial_src.send_pair({bval(4*k+1), bval(4*k)}, {bval(4*k+3), bval(4*k+2)}, sce, lsb, dly);
        for (int l = 0; l < nl && ser && pkt; l++)
            i_apk_serial_src.send_frame(ln + 2, l * ln, sce, lsb);
        wait_active(1'h0);
        repeat (4) @(posedge clock);
        n = (exp_q.size() > 35) ? 35 : exp_q.size();
        check({30'h0, cnt}, n, 36'h3F, "count");
        check({34'h0, full, afull}, {34'h0, n >= 34, n >= 32}, 36'h3, "flags");
        for (int i = 0; i < n; i++) begin
            pop <= 1'h1;
            @(posedge clock);
            pop <= 1'h0;
            @(negedge clock);
            check(q, exp_q[i], msk_q[i], "word");
            @(posedge clock);
        end
        check({30'h0, cnt}, 36'h0, 36'h3F, "count after drain");
        exp_q.delete();
        msk_q.delete();
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        check({26'h0, cnt, push, active, full, afull}, 36'h0, 36'h3FF, "reset state");
        buf_en <= 1'h1;
        run(1'h0, 1'h1, 6, 2);
        run(1'h0, 1'h0, 7, 1);
        run(1'h0, 1'h1, 136, 1);
        cap_en <= 1'h1;
        wait_active(1'h1);
        repeat (4) @(posedge clock);
        buf_en <= 1'h0;
        cap_en <= 1'h0;
        repeat (4) @(posedge clock);
        check({29'h0, cnt, active}, 36'h0, 36'h7F, "disabled state");
        buf_en <= 1'h1;
        for (int e = 0; e < 4; e++) begin
            sce <= e[0];
            lsb <= e[0];
            pkt <= e[1];
            dly <= (e == 1) ? 5'h03 : 5'h00;
            run(1'h1, 1'h0, e[1] ? 6 : 8, e[1] ? 2 : 1);
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
